// ===== logic/rtcu_core.sv
// rtcu_core: registers, update cycle, divider, flags and interrupt pin
// assumes bus pins already synchronous to mclk; counters and ram outside
`timescale 1ns/1ps
module rtcu_core
  import rtcu_pkg::*;
#(
  parameter int CSR_CYCLES = RTCU_CSR_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        reset_pin,
  input  wire logic        cs_n,
  input  wire logic        addr_strobe,
  input  wire logic        data_strobe,
  input  wire logic        read_not_write,
  input  wire logic        extended_ram_select,
  input  wire logic [7:0]  ad_in,
  output logic      [7:0]  ad_out,
  output logic             ad_oe,
  input  wire logic        power_fail,
  input  wire logic        backup_valid,
  input  wire logic        century_bit,
  input  wire rtcu_time_t  time_now,
  input  wire rtcu_alarm_t alarm_bytes,
  output rtcu_mode_t       mode,
  output rtcu_step_t       step,
  output logic             irq_n_out,
  output logic             irq_oe
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] to_bin(input logic [7:0] v,
                                        input logic       bin);
    to_bin = bin ? v : 8'((v[7:4] * 10) + v[3:0]);
  endfunction : to_bin

  function automatic logic [14:0] rate_mask(input logic [3:0] rs);
    logic [14:0] m;
    m = 15'h0000;
    if (rs == 4'h1) m = 15'h007F;
    else if (rs == 4'h2) m = 15'h00FF;
    else if (rs != 4'h0) m = 15'((16'h0001 << (rs - 4'h1)) - 16'h0001);
    rate_mask = m;
  endfunction : rate_mask

  typedef enum logic {UPD_IDLE, UPD_BUSY} rtcu_upd_t;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic [7:0]  addr_reg;
  logic        ds_q_reg;
  logic        wp_reg;
  logic [31:0] csr_cnt_reg;
  logic        rd_acc;
  logic        wr_take;
  logic        rd_end;

  assign rd_acc  = !cs_n && !extended_ram_select && data_strobe
                   && read_not_write;
  assign wr_take = !cs_n && !extended_ram_select && data_strobe
                   && !ds_q_reg && !read_not_write && !wp_reg;
  assign rd_end  = !cs_n && !extended_ram_select && !data_strobe
                   && ds_q_reg && read_not_write;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      addr_reg <= 8'h00;
      ds_q_reg <= 1'b0;
    end else if (ce) begin
      ds_q_reg <= data_strobe;
      if (addr_strobe && !cs_n) addr_reg <= ad_in;
    end
  end

  // write protect follows power fail plus a recovery hold
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wp_reg      <= 1'b1;
      csr_cnt_reg <= 32'h0000_0000;
    end else if (ce) begin
      if (power_fail) begin
        wp_reg      <= 1'b1;
        csr_cnt_reg <= 32'h0000_0000;
      end else if (wp_reg) begin
        csr_cnt_reg <= csr_cnt_reg + 32'h0000_0001;
        if (csr_cnt_reg >= 32'(CSR_CYCLES - 1)) wp_reg <= 1'b0;
      end
    end
  end

  logic wr_rate;
  logic wr_ctrl;
  logic wr_day;
  logic rd_flags_end;
  assign wr_rate = wr_take && (addr_reg == RTCU_ADDR_RATE);
  assign wr_ctrl = wr_take && (addr_reg == RTCU_ADDR_CTRL);
  assign wr_day  = wr_take && (addr_reg == RTCU_ADDR_DAY);
  // clearing on the strobe's fall keeps read data stable meanwhile
  assign rd_flags_end = rd_end && (addr_reg == RTCU_ADDR_FLAGS);

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [2:0] osc_reg;
  logic [3:0] rate_reg;
  logic       uti_reg, pie_reg, aie_reg, uie_reg;
  logic       df_reg, hf_reg, dse_reg;
  logic [5:0] day_alarm_reg;
  logic [6:0] sidx_reg, eidx_reg;
  logic       div_run;
  logic       osc_run;

  assign div_run = (osc_reg[2:1] == 2'b01);
  assign osc_run = div_run || (osc_reg[2:1] == 2'b11);

  // format and oscillator fields survive the reset pin
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      osc_reg       <= 3'h0;
      rate_reg      <= 4'h0;
      uti_reg       <= 1'b0;
      df_reg        <= 1'b0;
      hf_reg        <= 1'b0;
      dse_reg       <= 1'b0;
      day_alarm_reg <= 6'h00;
    end else if (ce) begin
      if (wr_rate) begin
        osc_reg  <= ad_in[6:4];
        rate_reg <= ad_in[3:0];
      end
      if (wr_ctrl) begin
        uti_reg <= ad_in[7];
        df_reg  <= ad_in[2];
        hf_reg  <= ad_in[1];
        dse_reg <= ad_in[0];
      end
      if (wr_day) day_alarm_reg <= ad_in[5:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pie_reg <= 1'b0;
      aie_reg <= 1'b0;
      uie_reg <= 1'b0;
    end else if (ce) begin
      if (reset_pin) begin
        pie_reg <= 1'b0;
        aie_reg <= 1'b0;
        uie_reg <= 1'b0;
      end else if (wr_ctrl) begin
        pie_reg <= ad_in[6];
        aie_reg <= ad_in[5];
        uie_reg <= ad_in[4] && !ad_in[7];
      end else if (uti_reg) begin
        uie_reg <= 1'b0;
      end
    end
  end

  // index copies of the last address seen on either bank
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sidx_reg <= 7'h00;
      eidx_reg <= 7'h00;
    end else if (ce) begin
      if (reset_pin) begin
        sidx_reg <= 7'h00;
        eidx_reg <= 7'h00;
      end else if (addr_strobe && !cs_n) begin
        if (extended_ram_select) eidx_reg <= ad_in[6:0];
        else sidx_reg <= ad_in[6:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // crystal rate and divider
  // ----------------------------------------------------------------
  logic [25:0] phase_reg;
  logic        xtick;
  logic [14:0] div_reg;

  assign xtick = (phase_reg >= 26'(RTCU_CLK_HZ - RTCU_XTAL_HZ));

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase_reg <= 26'h0000000;
    end else if (ce) begin
      if (!osc_run) phase_reg <= 26'h0000000;
      else if (xtick)
        phase_reg <= phase_reg + 26'(RTCU_XTAL_HZ) - 26'(RTCU_CLK_HZ);
      else phase_reg <= phase_reg + 26'(RTCU_XTAL_HZ);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_reg <= 15'h0000;
    end else if (ce) begin
      if (wr_rate && ad_in[6:4] == RTCU_OSC_RUN && !div_run)
        div_reg <= 15'(RTCU_HALF_SEC);
      else if (!div_run) div_reg <= 15'h0000;
      else if (xtick) div_reg <= div_reg + 15'h0001;
    end
  end

  // ----------------------------------------------------------------
  // update cycle
  // ----------------------------------------------------------------
  rtcu_upd_t upd_state;
  logic      uip_reg;
  logic      upd_start;
  logic      upd_end;
  logic      pre_point;

  // busy length stays below one tick-second minus the 999 ms gap
  assign upd_start = (upd_state == UPD_IDLE) && xtick && div_run
                     && !uti_reg && (div_reg == 15'(RTCU_DIV_MAX));
  assign upd_end   = (upd_state == UPD_BUSY) && xtick
                     && (div_reg == 15'(RTCU_UPD_TICKS - 1));
  assign pre_point = xtick && div_run && !uti_reg
                     && (div_reg == 15'(RTCU_DIV_MAX - RTCU_BUC_TICKS));

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      upd_state <= UPD_IDLE;
    end else if (ce) begin
      case (upd_state)
        UPD_IDLE: begin
          if (upd_start) upd_state <= UPD_BUSY;
        end
        UPD_BUSY: begin
          if (upd_end || !div_run) upd_state <= UPD_IDLE;
        end
        default: upd_state <= UPD_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      uip_reg <= 1'b0;
    end else if (ce) begin
      if (uti_reg || !div_run) uip_reg <= 1'b0;
      else if (pre_point) uip_reg <= 1'b1;
      else if (upd_end) uip_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // event flags and interrupt
  // ----------------------------------------------------------------
  logic       uf_reg, af_reg, pf_reg, irq_summary_flag_reg;
  logic       per_evt;
  logic       al_hit;
  logic [14:0] pmask;

  assign pmask   = rate_mask(rate_reg);
  // periodic edges share the divider, so with a nonzero rate each update starts on a periodic edge
  assign per_evt = xtick && div_run && (pmask != 15'h0000)
                   && ((div_reg & pmask) == pmask);
  assign al_hit  = ((alarm_bytes.sec[7:6] == 2'b11)
                    || alarm_bytes.sec == time_now.sec)
                   && ((alarm_bytes.min[7:6] == 2'b11)
                    || alarm_bytes.min == time_now.min)
                   && ((alarm_bytes.hour[7:6] == 2'b11)
                    || alarm_bytes.hour == time_now.hour)
                   && ((day_alarm_reg == 6'h00)
                    || {2'b00, day_alarm_reg} == time_now.dom);

  // a set in the clearing cycle wins over the read-clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      uf_reg   <= 1'b0;
      af_reg   <= 1'b0;
      pf_reg   <= 1'b0;
      irq_summary_flag_reg <= 1'b0;
    end else if (ce) begin
      if (reset_pin) begin
        uf_reg   <= 1'b0;
        af_reg   <= 1'b0;
        pf_reg   <= 1'b0;
        irq_summary_flag_reg <= 1'b0;
      end else begin
        uf_reg <= upd_end || (uf_reg && !rd_flags_end);
        af_reg <= (upd_end && al_hit) || (af_reg && !rd_flags_end);
        pf_reg <= per_evt || (pf_reg && !rd_flags_end);
        irq_summary_flag_reg <= (upd_end && uie_reg && !uti_reg)
                    || (upd_end && al_hit && aie_reg)
                    || (per_evt && pie_reg)
                    || (!rd_flags_end && ((uf_reg && uie_reg)
                        || (af_reg && aie_reg)
                        || (pf_reg && pie_reg)));
      end
    end
  end

  assign irq_n_out = 1'b0;
  assign irq_oe    = irq_summary_flag_reg;

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic       hit;
  logic [7:0] rd_mux;

  always_comb begin
    hit    = 1'b1;
    rd_mux = 8'h00;
    if (addr_reg == RTCU_ADDR_RATE) rd_mux = {uip_reg, osc_reg, rate_reg};
    else if (addr_reg == RTCU_ADDR_CTRL)
      rd_mux = {uti_reg, pie_reg, aie_reg, uie_reg, 1'b0,
                df_reg, hf_reg, dse_reg};
    else if (addr_reg == RTCU_ADDR_FLAGS)
      rd_mux = {irq_summary_flag_reg, pf_reg, af_reg, uf_reg, 4'h0};
    else if (addr_reg == RTCU_ADDR_DAY)
      rd_mux = {backup_valid, 1'b0, day_alarm_reg};
    else if (addr_reg == RTCU_ADDR_SIDX) rd_mux = {1'b0, sidx_reg};
    else if (addr_reg == RTCU_ADDR_EIDX) rd_mux = {century_bit, eidx_reg};
    else hit = 1'b0;
  end

  // open during update cycles too; unmapped bytes are left to the ram
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) ad_out <= 8'h00;
    else if (ce) ad_out <= rd_mux;
  end

  assign ad_oe = rd_acc && hit && ds_q_reg;

  // ----------------------------------------------------------------
  // daylight saving and mode outputs
  // ----------------------------------------------------------------
  logic       fell_reg;
  logic [7:0] b_hour, b_dom, b_mon, b_dow, b_min, b_sec;
  logic       at_159;
  logic       fall_now, spring_now;

  assign b_hour = to_bin(time_now.hour, df_reg);
  assign b_dom  = to_bin(time_now.dom, df_reg);
  assign b_mon  = to_bin(time_now.month, df_reg);
  assign b_dow  = to_bin(time_now.dow, df_reg);
  assign b_min  = to_bin(time_now.min, df_reg);
  assign b_sec  = to_bin(time_now.sec, df_reg);
  assign at_159 = (b_hour == 8'h01) && (b_min == 8'h3B)
                  && (b_sec == 8'h3B) && (b_dow == 8'h01);
  assign fall_now   = dse_reg && at_159 && (b_mon == 8'h0A)
                      && (b_dom >= 8'h19) && !fell_reg;
  assign spring_now = dse_reg && at_159 && (b_mon == 8'h04)
                      && (b_dom <= 8'h07);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fell_reg <= 1'b0;
    end else if (ce) begin
      if (upd_start && fall_now) fell_reg <= 1'b1;
      else if (upd_start && b_hour >= 8'h03) fell_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      step <= '0;
    end else if (ce) begin
      step.advance    <= upd_start;
      step.fall_back  <= upd_start && fall_now;
      step.spring_fwd <= upd_start && spring_now;
    end
  end

  assign mode.osc_run                = osc_run;
  assign mode.div_run                = div_run;
  assign mode.hour_format            = hf_reg;
  assign mode.data_format            = df_reg;
  assign mode.daylight_saving_enable = dse_reg;
  assign mode.write_protect          = wp_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  uf_on_end_a: assert property (@(posedge mclk) disable iff (rst)
    ce && upd_end && !reset_pin |=> uf_reg)
    else $error("update end did not set flag");
  upd_irq_a: assert property (@(posedge mclk) disable iff (rst)
    ce && upd_end && uie_reg && !uti_reg && !reset_pin |=> irq_oe)
    else $error("update irq missing");
  wr_blocked_a: assert property (@(posedge mclk) disable iff (rst)
    ce && power_fail |=> !wr_take)
    else $error("write taken during power fail");
  osc_stop_a: assert property (@(posedge mclk) disable iff (rst)
    !osc_run && ce |=> phase_reg == 26'h0000000)
    else $error("oscillator runs with stop code");
  uip_inhibit_a: assert property (@(posedge mclk) disable iff (rst)
    ce && uti_reg |=> !uip_reg)
    else $error("pending seen during inhibit");
  uip_before_a: assert property (@(posedge mclk) disable iff (rst)
    upd_start |-> uip_reg)
    else $error("update began without pending");
  uie_clear_a: assert property (@(posedge mclk) disable iff (rst)
    ce && uti_reg && !wr_ctrl |=> !uie_reg)
    else $error("update enable kept under inhibit");
  rdc_clear_a: assert property (@(posedge mclk) disable iff (rst)
    ce && rd_flags_end && !upd_end && !per_evt |=> !uf_reg && !pf_reg)
    else $error("flags not cleared by read");
  irq_pin_a: assert property (@(posedge mclk) disable iff (rst)
    irq_oe == irq_summary_flag_reg && !irq_n_out)
    else $error("irq pin not following summary");
  per_none_a: assert property (@(posedge mclk) disable iff (rst)
    rate_reg == 4'h0 |-> !per_evt)
    else $error("periodic event with rate zero");

endmodule : rtcu_core

// ===== logic/rtcu_pkg.sv
// rtcu_pkg: constants, field layouts and carriers of the clock control block
// assumes one 40 MHz clock; the time counters sit outside this block
package rtcu_pkg;

  // ----------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] RTCU_ADDR_RATE  = 8'h0A;
  localparam logic [7:0] RTCU_ADDR_CTRL  = 8'h0B;
  localparam logic [7:0] RTCU_ADDR_FLAGS = 8'h0C;
  localparam logic [7:0] RTCU_ADDR_DAY   = 8'h0D;
  localparam logic [7:0] RTCU_ADDR_SIDX  = 8'h7E;
  localparam logic [7:0] RTCU_ADDR_EIDX  = 8'h7F;
  localparam logic [2:0] RTCU_OSC_RUN    = 3'h2;
  localparam logic [7:0] RTCU_AL_DONTCARE = 8'hC0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int RTCU_CLK_HZ    = 40000000;
  localparam int RTCU_CLK_NS    = 25;
  localparam int RTCU_XTAL_HZ   = 32768;
  localparam int RTCU_DIV_MAX   = RTCU_XTAL_HZ - 1;
  localparam int RTCU_HALF_SEC  = RTCU_XTAL_HZ / 2;
  localparam int RTCU_GAP_MS    = 999;
  localparam int RTCU_BUC_US    = 244;
  localparam int RTCU_BUC_TICKS =
    (RTCU_BUC_US * RTCU_XTAL_HZ + 999999) / 1000000;
  localparam int RTCU_UPD_US    = 977;
  localparam int RTCU_UPD_TICKS = (RTCU_UPD_US * RTCU_XTAL_HZ) / 1000000;
  localparam int RTCU_CSR_US    = 200;
  localparam int RTCU_CSR_CYC   = (RTCU_CSR_US * 1000) / RTCU_CLK_NS;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] dow;
    logic [7:0] dom;
    logic [7:0] month;
  } rtcu_time_t;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
  } rtcu_alarm_t;

  typedef struct packed {
    logic osc_run;
    logic div_run;
    logic hour_format;
    logic data_format;
    logic daylight_saving_enable;
    logic write_protect;
  } rtcu_mode_t;

  typedef struct packed {
    logic advance;
    logic fall_back;
    logic spring_fwd;
  } rtcu_step_t;

endpackage : rtcu_pkg

// ===== tb/rtcu_host.sv
// rtcu_host: host bus master model for the multiplexed register bus
// assumes the block samples every bus pin on the rising edge of mclk
`timescale 1ns/1ps
module rtcu_host (
  input  wire logic       mclk,
  output logic            cs_n,
  output logic            addr_strobe,
  output logic            data_strobe,
  output logic            read_not_write,
  output logic            extended_ram_select,
  output logic [7:0]      ad_in,
  input  wire logic [7:0] ad_out,
  input  wire logic       ad_oe
);
  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  logic busy;
  initial begin
    busy = 1'b0;
    cs_n = 1'b1;
    addr_strobe = 1'b0;
    data_strobe = 1'b0;
    read_not_write = 1'b0;
    extended_ram_select = 1'b0;
    ad_in = 8'h5A;
  end
  // released bus toggles so a stale byte never looks valid
  always @(posedge mclk) begin
    if (!busy) begin
      ad_in <= ~ad_in;
    end
  end
  task automatic addr_phase(input logic ext, input logic [7:0] addr);
    busy = 1'b1;
    @(posedge mclk);
    cs_n <= 1'b0;
    addr_strobe <= 1'b1;
    extended_ram_select <= ext;
    ad_in <= addr;
    @(posedge mclk);
    addr_strobe <= 1'b0;
  endtask : addr_phase
  task automatic wr(input logic       ext,
                    input logic [7:0] a,
                    input logic [7:0] d);
    addr_phase(ext, a);
    @(posedge mclk);
    data_strobe <= 1'b1;
    read_not_write <= 1'b0;
    ad_in <= d;
    repeat (2) @(posedge mclk);
    data_strobe <= 1'b0;
    cs_n <= 1'b1;
    extended_ram_select <= 1'b0;
    busy = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    addr_phase(1'b0, a);
    @(posedge mclk);
    data_strobe <= 1'b1;
    read_not_write <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk);
      if (ad_oe === 1'b1) begin
        d = ad_out;
        ok = 1'b1;
        break;
      end
    end
    // select and direction outlive the strobe so the read-clear lands
    data_strobe <= 1'b0;
    @(posedge mclk);
    read_not_write <= 1'b0;
    cs_n <= 1'b1;
    busy = 1'b0;
  endtask : rd
endmodule : rtcu_host

// ===== tb/tb.sv
// tb: self-checking bench of the clock control block with a host model
// assumes one 40 MHz clock; update cycles lie beyond this run's length
`timescale 1ns/1ps
module tb;
  import rtcu_pkg::*;
  localparam int CSR = 16;
  logic        mclk, rst, ce, reset_pin, power_fail, backup_valid;
  logic        century_bit, cs_n, addr_strobe, data_strobe, read_not_write;
  logic        extended_ram_select, ad_oe, irq_n_out, irq_oe, ok;
  logic [7:0]  ad_in, ad_out, got, d, exp_day;
  rtcu_mode_t  mode;
  int          failures, checks_done, i;
  integer      seed;
  rtcu_core #(.CSR_CYCLES(CSR)) rtcu_core_inst (.mclk(mclk), .rst(rst),
    .ce(ce), .reset_pin(reset_pin), .cs_n(cs_n), .addr_strobe(addr_strobe),
    .data_strobe(data_strobe), .read_not_write(read_not_write),
    .extended_ram_select(extended_ram_select), .ad_in(ad_in),
    .ad_out(ad_out), .ad_oe(ad_oe), .power_fail(power_fail),
    .backup_valid(backup_valid), .century_bit(century_bit),
    .time_now(48'h0), .alarm_bytes(24'hC0C0C0), .mode(mode), .step(),
    .irq_n_out(irq_n_out), .irq_oe(irq_oe));
  rtcu_host rtcu_host_inst (.mclk(mclk), .cs_n(cs_n),
    .addr_strobe(addr_strobe), .data_strobe(data_strobe),
    .read_not_write(read_not_write),
    .extended_ram_select(extended_ram_select), .ad_in(ad_in),
    .ad_out(ad_out), .ad_oe(ad_oe));
  // ----------------------------------------------------------------
  // checks and verdict
  // ----------------------------------------------------------------
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic g, input logic e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_bit
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    rtcu_host_inst.rd(a, got, ok);
    chk_bit(ok, 1'b1);
    chk_byte(got, e);
  endtask : rchk
  task automatic give_verdict;
    if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;
  // periodic waits dominate; two and a half times their sum leaves room
  initial begin
    #1500000;
    failures++;
    give_verdict;
  end
  initial begin
    seed = 32'hf8f82f4f;
    failures = 0;
    checks_done = 0;
    rst = 1'b1;
    ce = 1'b1;
    reset_pin = 1'b0;
    power_fail = 1'b0;
    backup_valid = 1'($random(seed));
    century_bit = 1'($random(seed));
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    chk_bit(mode.write_protect, 1'b1);
    rtcu_host_inst.wr(1'b0, RTCU_ADDR_CTRL, 8'h06);
    rchk(RTCU_ADDR_CTRL, 8'h00);
    repeat (CSR) @(posedge mclk);
    rtcu_host_inst.wr(1'b0, RTCU_ADDR_FLAGS, 8'hFF);
    rchk(RTCU_ADDR_FLAGS, 8'h00);
    for (i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      d[6:4] = 3'(i);
      rtcu_host_inst.wr(1'b0, RTCU_ADDR_RATE, d);
      rchk(RTCU_ADDR_RATE, d & 8'h7F);
      chk_bit(mode.osc_run, i[1]);
      chk_bit(mode.div_run, i[2:1] == 2'b01);
    end
    rtcu_host_inst.wr(1'b0, RTCU_ADDR_CTRL, 8'h97);
    rchk(RTCU_ADDR_CTRL, 8'h87);
    chk_bit(mode.data_format, 1'b1);
    chk_bit(mode.hour_format, 1'b1);
    rchk(RTCU_ADDR_RATE, {1'b0, d[6:0]});
    d = 8'($random(seed));
    exp_day = {backup_valid, 1'b0, d[5:0]};
    rtcu_host_inst.wr(1'b0, RTCU_ADDR_DAY, d);
    rchk(RTCU_ADDR_DAY, exp_day);
    @(posedge mclk) power_fail <= 1'b1;
    rtcu_host_inst.wr(1'b0, RTCU_ADDR_CTRL, 8'h02);
    rchk(RTCU_ADDR_CTRL, 8'h87);
    @(posedge mclk) power_fail <= 1'b0;
    rtcu_host_inst.wr(1'b0, RTCU_ADDR_CTRL, 8'h02);
    rchk(RTCU_ADDR_CTRL, 8'h87);
    repeat (CSR) @(posedge mclk);
    rtcu_host_inst.wr(1'b0, RTCU_ADDR_CTRL, 8'h02);
    rchk(RTCU_ADDR_CTRL, 8'h02);
    rtcu_host_inst.rd(8'h20, got, ok);
    chk_bit(ok, 1'b0);
    // periodic source at 122 us with only its enable set
    rtcu_host_inst.wr(1'b0, RTCU_ADDR_RATE, 8'h23);
    d = 8'h40 | (8'($random(seed)) & 8'h07);
    rtcu_host_inst.wr(1'b0, RTCU_ADDR_CTRL, d);
    rtcu_host_inst.rd(RTCU_ADDR_FLAGS, got, ok);
    for (i = 0; i < 12000 && irq_oe !== 1'b1; i++) @(posedge mclk);
    chk_bit(irq_oe, 1'b1);
    chk_bit(irq_n_out, 1'b0);
    rchk(RTCU_ADDR_FLAGS, 8'hC0);
    @(posedge mclk);
    chk_bit(irq_oe, 1'b0);
    rtcu_host_inst.wr(1'b0, RTCU_ADDR_RATE, 8'h20);
    rtcu_host_inst.rd(RTCU_ADDR_FLAGS, got, ok);
    repeat (12000) @(posedge mclk);
    chk_bit(irq_oe, 1'b0);
    rchk(RTCU_ADDR_FLAGS, 8'h00);
    // index copies, then the documented reset input
    rtcu_host_inst.wr(1'b0, RTCU_ADDR_CTRL, 8'h76);
    rtcu_host_inst.wr(1'b1, 8'h25, 8'h00);
    rtcu_host_inst.wr(1'b0, RTCU_ADDR_EIDX, 8'h55);
    rchk(RTCU_ADDR_EIDX, {century_bit, 7'h25});
    rchk(RTCU_ADDR_SIDX, 8'h7E);
    @(posedge mclk) reset_pin <= 1'b1;
    @(posedge mclk) reset_pin <= 1'b0;
    rchk(RTCU_ADDR_CTRL, 8'h06);
    rchk(RTCU_ADDR_EIDX, {century_bit, 7'h00});
    rchk(RTCU_ADDR_DAY, exp_day);
    rchk(RTCU_ADDR_RATE, 8'h20);
    give_verdict;
  end
endmodule : tb
